/* File: core/mmdec_pkg.sv */
/*
  package of the memory map decoder: address regions, register offsets,
  field positions, reset values and the bus carriers.
  assumes a single 8-bit cpu core with 16-bit code and data addresses.
*/
// Operation
// - code and data spaces are separate 64 KB spaces decoded independently
// - code addresses 0x8000 to 0xffff select the flash after reset
// - data addresses 0x8000 to 0xffff select the flash after reset
// - data space has register regions 0x0000-0x003f, 0x0f00-0x0fff, 0x0e40-0x0eff
// - data addresses 0x0040 to 0x083f select the ram after reset
// - boot rom stays unmapped after reset until enabled and committed
// - active boot select maps boot rom at 0x1000-0x17ff in both spaces
// - only the first 2 KB of boot rom are visible outside serial prom mode
// - unmapped boot window reads 0xff in data space
// - control writes are buffered and copied to active only on commit code 0xd5
// - commit register is write only; any other value commits nothing
// - the active control value is readable through a separate view register
package mmdec_pkg;

  // ==========================================================================
  // address regions
  localparam logic [15:0] FLASH_LO   = 16'h8000;
  localparam logic [15:0] FLASH_HI   = 16'hffff;
  localparam logic [15:0] SFR1_LO    = 16'h0000;
  localparam logic [15:0] SFR1_HI    = 16'h003f;
  localparam logic [15:0] SFR2_LO    = 16'h0f00;
  localparam logic [15:0] SFR2_HI    = 16'h0fff;
  localparam logic [15:0] SFR3_LO    = 16'h0e40;
  localparam logic [15:0] SFR3_HI    = 16'h0eff;
  localparam logic [15:0] RAM_LO     = 16'h0040;
  localparam logic [15:0] RAM_HI     = 16'h083f;
  localparam logic [15:0] BOOT_LO    = 16'h1000;
  localparam logic [15:0] BOOT_HI    = 16'h17ff;

  // ==========================================================================
  // registers
  localparam logic [15:0] CTRL_BUF_OFS = 16'h0fd0;
  localparam logic [15:0] COMMIT_OFS   = 16'h0fd1;
  localparam logic [15:0] VIEW_OFS     = 16'h0fd2;
  localparam logic [7:0]  CTRL_RESET   = 8'h40;
  localparam logic [7:0]  COMMIT_CODE  = 8'hd5;
  localparam logic [7:0]  UNMAPPED_RD  = 8'hff;
  localparam int          BOOT_SEL_BIT = 1;

  // ==========================================================================
  // decode result
  typedef enum logic [2:0] {
    MMDEC_NONE  = 3'b000,
    MMDEC_FLASH = 3'b001,
    MMDEC_RAM   = 3'b010,
    MMDEC_SFR   = 3'b011,
    MMDEC_BOOT  = 3'b100
  } mmdec_region_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } mmdec_data_req_s;

  typedef struct packed {
    mmdec_region_e region;
    logic [15:0]   offset;
  } mmdec_sel_s;

endpackage : mmdec_pkg

/* File: core/mmdec_top.sv */
/*
  memory map decoder: selects flash and the boot rom window for the fetch bus, and
  flash, ram, register regions and the boot rom window for the data bus, and holds the double-buffered boot
  mapping control with its commit and view registers.
  assumes cpu buses synchronous to sys_clk; read data of the memories arrives
  on the same clock and is steered back through this block.
*/
`timescale 1ns/1ps
module mmdec_top #(
  parameter int BOOT_WIN_BYTES = 2048
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  // mode strap
  input  wire logic                       serial_prom_mode,
  // code fetch bus
  input  wire logic [15:0]                code_addr,
  // data bus
  input  wire mmdec_pkg::mmdec_data_req_s data_req,
  // memory and register region read data
  input  wire logic [7:0]                 mem_rdata,
  // selections
  output logic                            code_sel_flash_q,
  output logic                            code_sel_boot_q,
  output mmdec_pkg::mmdec_sel_s           data_sel_q,
  output logic                            data_wr_q,
  output logic                            data_rd_q,
  output logic [7:0]                      data_wdata_q,
  // read data to core and control state
  output logic [7:0]                      data_rdata_q,
  output logic [7:0]                      ctrl_active_q
);

  // ==========================================================================
  // decode helpers
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic in_boot(input logic [15:0] a, input logic serial_mode);
    logic [15:0] hi;
    hi = serial_mode ? mmdec_pkg::BOOT_HI :
         16'(mmdec_pkg::BOOT_LO + 16'(BOOT_WIN_BYTES) - 16'h0001);
    in_boot = in_range(a, mmdec_pkg::BOOT_LO, hi);
  endfunction : in_boot

  // ==========================================================================
  // strap synchroniser
  logic mode_meta_q;
  logic mode_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_meta_q <= 1'b0;
      mode_q      <= 1'b0;
    end else begin
      mode_meta_q <= serial_prom_mode;
      mode_q      <= mode_meta_q;
    end
  end

  // ==========================================================================
  // control registers
  logic [7:0] ctrl_buf_q;
  logic       wr_buf;
  logic       wr_commit;
  assign wr_buf    = data_req.wr && (data_req.addr == mmdec_pkg::CTRL_BUF_OFS);
  assign wr_commit = data_req.wr && (data_req.addr == mmdec_pkg::COMMIT_OFS);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_buf_q <= mmdec_pkg::CTRL_RESET;
    end else if (wr_buf) begin
      ctrl_buf_q <= data_req.wdata;
    end
  end

  // commit register holds no state; only the code has an effect
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_active_q <= mmdec_pkg::CTRL_RESET;
    end else if (wr_commit && (data_req.wdata == mmdec_pkg::COMMIT_CODE)) begin
      ctrl_active_q <= ctrl_buf_q;
    end
  end

  logic boot_on;
  assign boot_on = ctrl_active_q[mmdec_pkg::BOOT_SEL_BIT];

  // ==========================================================================
  // code space decode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      code_sel_flash_q <= 1'b0;
      code_sel_boot_q  <= 1'b0;
    end else begin
      code_sel_flash_q <= in_range(code_addr, mmdec_pkg::FLASH_LO, mmdec_pkg::FLASH_HI);
      code_sel_boot_q  <= boot_on && in_boot(code_addr, mode_q);
    end
  end

  // ==========================================================================
  // data space decode
  mmdec_pkg::mmdec_region_e data_region;
  logic [15:0]              data_ofs;
  logic                     reg_hit;
  always_comb begin
    data_region = mmdec_pkg::MMDEC_NONE;
    data_ofs    = 16'h0000;
    if (in_range(data_req.addr, mmdec_pkg::FLASH_LO, mmdec_pkg::FLASH_HI)) begin
      data_region = mmdec_pkg::MMDEC_FLASH;
      data_ofs    = 16'(data_req.addr - mmdec_pkg::FLASH_LO);
    end else if (in_range(data_req.addr, mmdec_pkg::SFR1_LO, mmdec_pkg::SFR1_HI) ||
                 in_range(data_req.addr, mmdec_pkg::SFR2_LO, mmdec_pkg::SFR2_HI) ||
                 in_range(data_req.addr, mmdec_pkg::SFR3_LO, mmdec_pkg::SFR3_HI)) begin
      data_region = mmdec_pkg::MMDEC_SFR;
      data_ofs    = data_req.addr;
    end else if (in_range(data_req.addr, mmdec_pkg::RAM_LO, mmdec_pkg::RAM_HI)) begin
      data_region = mmdec_pkg::MMDEC_RAM;
      data_ofs    = 16'(data_req.addr - mmdec_pkg::RAM_LO);
    end else if (boot_on && in_boot(data_req.addr, mode_q)) begin
      data_region = mmdec_pkg::MMDEC_BOOT;
      data_ofs    = 16'(data_req.addr - mmdec_pkg::BOOT_LO);
    end
  end

  // block's own registers are served here and not forwarded
  assign reg_hit = (data_req.addr == mmdec_pkg::CTRL_BUF_OFS) ||
                   (data_req.addr == mmdec_pkg::COMMIT_OFS) ||
                   (data_req.addr == mmdec_pkg::VIEW_OFS);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      data_sel_q   <= '{region: mmdec_pkg::MMDEC_NONE, offset: 16'h0000};
      data_wr_q    <= 1'b0;
      data_rd_q    <= 1'b0;
      data_wdata_q <= 8'h00;
    end else begin
      data_sel_q   <= '{region: data_region, offset: data_ofs};
      data_wr_q    <= data_req.wr && !reg_hit && (data_region != mmdec_pkg::MMDEC_NONE);
      data_rd_q    <= data_req.rd && !reg_hit && (data_region != mmdec_pkg::MMDEC_NONE);
      data_wdata_q <= data_req.wdata;
    end
  end

  // ==========================================================================
  // read data: local registers answer two cycles after the request, as memory reads do
  logic       local_rd_q;
  logic [7:0] local_data_q;
  logic       ff_rd_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      local_rd_q   <= 1'b0;
      local_data_q <= 8'h00;
      ff_rd_q      <= 1'b0;
    end else begin
      local_rd_q <= data_req.rd && reg_hit;
      if (data_req.addr == mmdec_pkg::VIEW_OFS) begin
        local_data_q <= ctrl_active_q;
      end else if (data_req.addr == mmdec_pkg::CTRL_BUF_OFS) begin
        local_data_q <= ctrl_buf_q;
      end else begin
        local_data_q <= 8'h00;
      end
      ff_rd_q <= data_req.rd && !reg_hit && (data_region == mmdec_pkg::MMDEC_NONE) &&
                 in_range(data_req.addr, mmdec_pkg::BOOT_LO, mmdec_pkg::BOOT_HI);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      data_rdata_q <= 8'h00;
    end else if (local_rd_q) begin
      data_rdata_q <= local_data_q;
    end else if (ff_rd_q) begin
      data_rdata_q <= mmdec_pkg::UNMAPPED_RD;
    end else if (data_rd_q) begin
      data_rdata_q <= mem_rdata;
    end
  end

endmodule : mmdec_top

/* File: testbench/mmdec_sva.sv */
/* port checker of the decoder; bound to mmdec_top from the bench top file */
`timescale 1ns/1ps
module mmdec_sva (
  input wire logic                       sys_clk, resetn, serial_prom_mode,
  input wire logic [15:0]                code_addr,
  input wire mmdec_pkg::mmdec_data_req_s data_req,
  input wire logic [7:0]                 mem_rdata, data_wdata_q, data_rdata_q, ctrl_active_q,
  input wire logic                       code_sel_flash_q, code_sel_boot_q, data_wr_q, data_rd_q,
  input wire mmdec_pkg::mmdec_sel_s      data_sel_q
);
  wire logic [15:0] a     = data_req.addr;
  wire logic        boot  = (a >= 16'h1000) && (a <= 16'h17ff);
  wire logic        cboot = (code_addr >= 16'h1000) && (code_addr <= 16'h17ff);
  wire logic        sel   = ctrl_active_q[mmdec_pkg::BOOT_SEL_BIT];
  wire logic        ram   = (a >= 16'h0040) && (a <= 16'h083f);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // decode and control
  chk_code_flash: assert property ($past(resetn) |-> code_sel_flash_q == $past(code_addr[15]))
    else $error("code flash select wrong");
  chk_data_flash: assert property (data_req.rd && a[15] |=> data_rd_q && data_sel_q.region == 3'h1)
    else $error("data flash select wrong");
  chk_ram_sel: assert property (data_req.rd && ram |=> data_sel_q.region == 3'h2 &&
    data_sel_q.offset == $past(a) - 16'h0040) else $error("ram select wrong");
  chk_sfr_sel: assert property (data_req.rd && (a <= 16'h003f || (a >= 16'h0e40 && a <= 16'h0eff))
    |=> data_rd_q && data_sel_q.region == 3'h3) else $error("register region select wrong");
  chk_boot_off: assert property (data_req.rd && boot && !sel |=> !data_rd_q ##1 data_rdata_q == 8'hff)
    else $error("unmapped boot read wrong");
  chk_boot_on: assert property (data_req.rd && boot && sel |=> data_sel_q.region == 3'h4 &&
    data_sel_q.offset == $past(a) - 16'h1000) else $error("boot data select wrong");
  chk_code_boot: assert property ($past(resetn) |-> code_sel_boot_q == ($past(cboot) && $past(sel)))
    else $error("code boot select wrong");
  chk_commit_only: assert property (!(data_req.wr && a == 16'h0fd1 && data_req.wdata == 8'hd5)
    |=> $stable(ctrl_active_q)) else $error("active control changed without commit");
  chk_rdata_pass: assert property (data_rd_q |=> data_rdata_q == $past(mem_rdata))
    else $error("read data not returned");
  chk_own_regs: assert property (data_req.wr && a >= 16'h0fd0 && a <= 16'h0fd2 |=> !data_wr_q)
    else $error("own register write forwarded");
  chk_wr_fwd: assert property (data_req.wr && ram |=> data_wr_q && data_wdata_q == $past(data_req.wdata))
    else $error("ram write not forwarded");
  cov_boot_on: cover property (data_req.rd && boot && sel);
  cov_boot_off: cover property (data_req.rd && boot && !sel);
  cov_commit: cover property (data_req.wr && a == 16'h0fd1 && data_req.wdata == 8'hd5);
endmodule : mmdec_sva

/* File: testbench/mmdec_mem_model.sv */
/* region side responder: answers forwarded reads; assumes the decoder strobes */
`timescale 1ns/1ps
module mmdec_mem_model (
  // decoder side
  input  wire logic                  sys_clk,
  input  wire logic                  data_rd_q,
  input  wire mmdec_pkg::mmdec_sel_s data_sel_q,
  output logic [7:0]                 mem_rdata
);
  logic [7:0] junk_q = 8'h00;
  // ==========================================================================
  // data derived from the offset in the strobe cycle, a running pattern otherwise
  always @(posedge sys_clk) junk_q <= junk_q + 8'h01;
  assign mem_rdata = data_rd_q ? (data_sel_q.offset[7:0] ^ 8'h5a) : junk_q;
endmodule : mmdec_mem_model

/* File: testbench/test_memory_map_decoder.sv */
/* bench top of the decoder; needs the package, design, model and checker */
`timescale 1ns/1ps
module test_memory_map_decoder;
  logic                       sys_clk = 1'b0, resetn = 1'b0, serial_prom_mode = 1'b0;
  logic [15:0]                code_addr = 16'h0000;
  mmdec_pkg::mmdec_data_req_s data_req = '0;
  logic [7:0]                 mem_rdata, data_wdata_q, data_rdata_q, ctrl_active_q;
  logic                       code_sel_flash_q, code_sel_boot_q, data_wr_q, data_rd_q;
  mmdec_pkg::mmdec_sel_s      data_sel_q;
  int                         err_total = 0, checks = 0;
  logic [15:0] ta [8] = '{16'h8000, 16'hffff, 16'h0000, 16'h003f, 16'h0e40, 16'h0eff, 16'h0040, 16'h083f};
  logic [2:0]  tr [8] = '{3'h1, 3'h1, 3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2};
  mmdec_top uut (.sys_clk, .resetn, .serial_prom_mode, .code_addr, .data_req, .mem_rdata, .code_sel_flash_q,
    .code_sel_boot_q, .data_sel_q, .data_wr_q, .data_rd_q, .data_wdata_q, .data_rdata_q, .ctrl_active_q);
  mmdec_mem_model model (.sys_clk, .data_rd_q, .data_sel_q, .mem_rdata);
  initial forever #2.5 sys_clk = ~sys_clk;
  // ==========================================================================
  // access tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [7:0] ex(input logic [15:0] a, input logic [2:0] r);
    logic [15:0] o;
    o = a - ((r == 3'h1) ? 16'h8000 : (r == 3'h2) ? 16'h0040 : (r == 3'h4) ? 16'h1000 : 16'h0000);
    return o[7:0] ^ 8'h5a;
  endfunction : ex
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1 data_req = {a, d, 2'b01};
    @(posedge sys_clk) #1 data_req.wr = 1'b0;
  endtask : wr
  // region 7 skips the region compare
  task automatic rd(input logic [15:0] a, input logic [2:0] r, input logic [7:0] d);
    @(posedge sys_clk) #1 data_req = {a, 8'h00, 2'b10};
    @(posedge sys_clk) #1 data_req.rd = 1'b0;
    if (r != 3'h7) cmp(data_sel_q.region, r);
    @(posedge sys_clk) #1 cmp(data_rdata_q, d);
  endtask : rd
  task automatic fetch(input logic [15:0] a, input logic [1:0] e);
    @(posedge sys_clk) #1 code_addr = a;
    @(posedge sys_clk) #1 cmp({code_sel_flash_q, code_sel_boot_q}, e);
  endtask : fetch
  task automatic conclude();
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // ==========================================================================
  // tests
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 resetn = 1'b1;
    cmp(ctrl_active_q, 8'h40);
    for (int i = 0; i < 8; i++) rd(ta[i], tr[i], ex(ta[i], tr[i]));
    rd(16'h1000, 3'h0, 8'hff);
    fetch(16'h8000, 2'b10);
    fetch(16'h7fff, 2'b00);
    fetch(16'h1000, 2'b00);
    wr(16'h0040, 8'h3c);
    wr(16'h0fd0, 8'h42);
    rd(16'h0fd2, 3'h7, 8'h40);
    wr(16'h0fd1, 8'hd4);
    rd(16'h0fd2, 3'h7, 8'h40);
    rd(16'h0fd1, 3'h7, 8'h00);
    wr(16'h0fd1, 8'hd5);
    cmp(ctrl_active_q, 8'h42);
    wr(16'h0fd2, 8'h00);
    rd(16'h0fd2, 3'h7, 8'h42);
    rd(16'h1000, 3'h4, ex(16'h1000, 3'h4));
    serial_prom_mode = 1'b1;
    rd(16'h17ff, 3'h4, ex(16'h17ff, 3'h4));
    fetch(16'h17ff, 2'b01);
    serial_prom_mode = 1'b0;
    wr(16'h0fd0, 8'h40);
    wr(16'h0fd1, 8'hd5);
    rd(16'h1000, 3'h0, 8'hff);
    fetch(16'h1000, 2'b00);
    conclude();
  end
  initial begin
    #10000;
    err_total++;
    conclude();
  end
endmodule : test_memory_map_decoder
bind mmdec_top mmdec_sva chk (.sys_clk, .resetn, .serial_prom_mode, .code_addr, .data_req, .mem_rdata,
  .data_wdata_q, .data_rdata_q, .ctrl_active_q, .code_sel_flash_q, .code_sel_boot_q, .data_wr_q, .data_rd_q,
  .data_sel_q);
